/* File: hw/urxq_defs.svh */
// constants for the receive status queue: offsets, fields, codes, reset values
`ifndef URXQ_DEFS_SVH
`define URXQ_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define URXQ_OFS_PEEK 8'h1C
`define URXQ_OFS_POP 8'h20
`define URXQ_OFS_SIZE 8'h24
`define URXQ_OFS_IRQ_STS 8'h40
`define URXQ_OFS_IRQ_MASK 8'h44

// ****************************************
// fields and values
// ****************************************
`define URXQ_ENTRY_W 21
`define URXQ_SIZE_RESET 16'h0200
`define URXQ_SIZE_MAX 16'h0400
`define URXQ_BIT_POPEV 0
`define URXQ_BIT_DROP 1
`define URXQ_BIT_NEMPTY 4
`define URXQ_IRQ_BITS 8'h13
`define URXQ_PS_OUT_NAK 4'h1
`define URXQ_PS_DATA 4'h2
`define URXQ_PS_DONE 4'h3
`define URXQ_PS_SETUP_DONE 4'h4
`define URXQ_PS_TOGGLE_ERR 4'h5
`define URXQ_PS_SETUP_DATA 4'h6
`define URXQ_PS_HALTED 4'h7
`define URXQ_RESP_OKAY 2'h0
`define URXQ_RESP_SLVERR 2'h2
`endif

/* File: hw/urxq_pkg.sv */
// types shared by the receive status queue modules
package urxq_pkg;
  typedef enum logic {ROLE_DEVICE, ROLE_HOST} urxq_role_e;
  // low 21 bits of a status word; bits 3:0 are channel (host) or endpoint (device)
  typedef struct packed {
    logic [3:0] packet_status;
    logic [1:0] data_pid_field;
    logic [10:0] byte_count_field;
    logic [3:0] channel_number;
  } urxq_entry_s;
endpackage : urxq_pkg

/* File: hw/urxq_fifo.sv */
// status entry queue with a live top entry and a fill count
`timescale 1ns/1ps
module urxq_fifo #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_push,
  input wire urxq_pkg::urxq_entry_s i_entry,
  input wire logic i_pop,
  output urxq_pkg::urxq_entry_s o_top,
  output logic [AW:0] o_count
);
  urxq_pkg::urxq_entry_s mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic do_pop;

  // callers guarantee push only when not full; pop of an empty queue is dropped
  assign do_pop = i_pop && (o_count != '0);
  assign o_top = mem[rd_ptr];

  always_ff @(posedge i_sys_clk) begin
    if (i_push) begin
      mem[wr_ptr] <= i_entry;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      o_count <= '0;
    end else begin
      if (i_push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      o_count <= o_count + (AW+1)'(i_push) - (AW+1)'(do_pop);
    end
  end
endmodule : urxq_fifo

/* File: hw/urxq_classify.sv */
// role-dependent decode of a packet status code
`timescale 1ns/1ps
`include "urxq_defs.svh"
module urxq_classify (
  input wire urxq_pkg::urxq_role_e i_role,
  input wire logic [3:0] i_code,
  output logic o_irq_on_pop,
  output logic o_known
);
  always_comb begin
    o_irq_on_pop = 1'b0;
    o_known = 1'b0;
    if (i_role == urxq_pkg::ROLE_HOST) begin
      case (i_code)
        `URXQ_PS_DATA: o_known = 1'b1;
        `URXQ_PS_DONE, `URXQ_PS_TOGGLE_ERR, `URXQ_PS_HALTED: begin
          o_known = 1'b1;
          o_irq_on_pop = 1'b1;
        end
        default: o_known = 1'b0;
      endcase
    end else begin
      case (i_code)
        `URXQ_PS_DATA, `URXQ_PS_SETUP_DATA: o_known = 1'b1;
        `URXQ_PS_OUT_NAK, `URXQ_PS_DONE, `URXQ_PS_SETUP_DONE: begin
          o_known = 1'b1;
          o_irq_on_pop = 1'b1;
        end
        default: o_known = 1'b0;
      endcase
    end
  end
endmodule : urxq_classify

/* File: hw/urxq_top.sv */
// receive status queue with AXI4-Lite registers and interrupt
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "urxq_defs.svh"
module urxq_top #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire urxq_pkg::urxq_role_e i_role,
  input wire logic i_rx_valid,
  input wire urxq_pkg::urxq_entry_s i_rx_entry,
  output logic o_rx_ready,
  output logic o_irq,
  output logic o_rx_not_empty,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp
);
  // ****************************************
  // queue and decode
  // ****************************************
  urxq_pkg::urxq_entry_s top;
  logic [AW:0] count;
  logic push;
  logic pop_req;
  logic popped;
  logic irq_on_pop;
  logic [15:0] rx_fifo_size;
  logic [AW:0] cap;
  logic [AW:0] next_count;

  assign push = i_rx_valid && o_rx_ready;
  assign popped = pop_req && (count != '0);

  urxq_fifo #(.DEPTH(DEPTH), .AW(AW)) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_push(push),
    .i_entry(i_rx_entry),
    .i_pop(popped),
    .o_top(top),
    .o_count(count)
  );

  urxq_classify u_cls (
    .i_role(i_role),
    .i_code(top.packet_status),
    .o_irq_on_pop(irq_on_pop),
    .o_known()
  );

  // depth in words caps the entry count; buffer size bounds it as well
  always_comb begin
    if (rx_fifo_size == 16'h0000) begin
      cap = '0;
    end else if (rx_fifo_size >= 16'(DEPTH)) begin
      cap = (AW+1)'(DEPTH);
    end else begin
      cap = rx_fifo_size[AW:0];
    end
  end

  assign next_count = count + (AW+1)'(push) - (AW+1)'(popped);

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rx_ready <= 1'b0;
      o_rx_not_empty <= 1'b0;
    end else begin
      o_rx_ready <= next_count < cap;
      o_rx_not_empty <= next_count != '0;
    end
  end

  // ****************************************
  // write channel
  // ****************************************
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic have_aw;
  logic have_w;
  logic do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_full;
  logic [7:0] irq_sts;
  logic [7:0] irq_mask;
  logic [7:0] sts_clr;
  logic [7:0] sts_set;

  assign have_aw = aw_got || (i_awvalid && o_awready);
  assign have_w = w_got || (i_wvalid && o_wready);
  assign do_write = have_aw && have_w && !o_bvalid;
  assign wr_addr = aw_got ? aw_addr : i_awaddr;
  assign wr_data = w_got ? w_data : i_wdata;
  assign wr_full = (w_got ? w_strb : i_wstrb) == 4'hF;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= `URXQ_RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        o_awready <= 1'b0;
        aw_addr <= i_awaddr;
        aw_got <= !do_write;
      end
      if (i_wvalid && o_wready) begin
        o_wready <= 1'b0;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
        w_got <= !do_write;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        o_bvalid <= 1'b1;
        if (!wr_full) begin
          o_bresp <= `URXQ_RESP_SLVERR;
        end else begin
          case (wr_addr)
            `URXQ_OFS_SIZE, `URXQ_OFS_IRQ_STS, `URXQ_OFS_IRQ_MASK: o_bresp <= `URXQ_RESP_OKAY;
            default: o_bresp <= `URXQ_RESP_SLVERR;
          endcase
        end
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_fifo_size <= `URXQ_SIZE_RESET;
      irq_mask <= 8'h00;
    end else if (do_write && wr_full) begin
      if (wr_addr == `URXQ_OFS_SIZE) begin
        rx_fifo_size <= wr_data[15:0];
      end
      if (wr_addr == `URXQ_OFS_IRQ_MASK) begin
        irq_mask <= wr_data[7:0] & `URXQ_IRQ_BITS;
      end
    end
  end

  // ****************************************
  // interrupt status
  // ****************************************
  always_comb begin
    sts_clr = 8'h00;
    sts_set = 8'h00;
    if (do_write && wr_full && wr_addr == `URXQ_OFS_IRQ_STS) begin
      sts_clr = wr_data[7:0];
    end
    sts_set[`URXQ_BIT_POPEV] = popped && irq_on_pop;
    sts_set[`URXQ_BIT_DROP] = i_rx_valid && !o_rx_ready && cap != '0;
  end

  // sticky bits: a set in the clearing cycle survives; not-empty is a live level
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_sts <= 8'h00;
      o_irq <= 1'b0;
    end else begin
      irq_sts <= (irq_sts & ~sts_clr) | sts_set;
      irq_sts[`URXQ_BIT_NEMPTY] <= next_count != '0;
      o_irq <= |((((irq_sts & ~sts_clr) | sts_set) & irq_mask & 8'h03)
        | ({3'b000, next_count != '0, 4'h0} & irq_mask));
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  logic [31:0] top_word;

  // unused high bits always zero regardless of what the link sent
  assign top_word = (count == '0) ? 32'h0000_0000 : {11'h000, top};

  assign pop_req = i_arvalid && o_arready && i_araddr == `URXQ_OFS_POP;

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= `URXQ_RESP_OKAY;
    end else begin
      if (i_arvalid && o_arready) begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rresp <= `URXQ_RESP_OKAY;
        case (i_araddr)
          `URXQ_OFS_PEEK, `URXQ_OFS_POP: o_rdata <= top_word;
          `URXQ_OFS_SIZE: o_rdata <= {16'h0000, rx_fifo_size};
          `URXQ_OFS_IRQ_STS: o_rdata <= {24'h000000, irq_sts};
          `URXQ_OFS_IRQ_MASK: o_rdata <= {24'h000000, irq_mask};
          default: begin
            o_rdata <= 32'h0000_0000;
            o_rresp <= `URXQ_RESP_SLVERR;
          end
        endcase
      end
      if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // o_irq follows a mask write one cycle late, so gating checks want a stable mask

  chk_peek_keeps: assert property (
    (i_arvalid && o_arready && i_araddr == `URXQ_OFS_PEEK && !push) |=> count == $past(count))
    else $error("peek changed the entry count");
  chk_pop_removes: assert property (
    (pop_req && count != '0 && !push) |=> count == $past(count) - 1'b1)
    else $error("pop did not remove one entry");
  chk_pop_data: assert property (
    (pop_req && count != '0) |=> o_rvalid && o_rdata == {11'h000, $past(top)})
    else $error("pop returned wrong entry");
  chk_reserved_zero: assert property (
    o_rvalid && ($past(i_araddr) == `URXQ_OFS_PEEK) |-> o_rdata[31:21] == 11'h000)
    else $error("reserved entry bits not zero");
  chk_host_irq: assert property (
    (popped && i_role == urxq_pkg::ROLE_HOST && top.packet_status == `URXQ_PS_DATA
      && !irq_sts[`URXQ_BIT_POPEV]) |=> !irq_sts[`URXQ_BIT_POPEV])
    else $error("host data entry raised pop interrupt");
  chk_dev_irq: assert property (
    (popped && i_role == urxq_pkg::ROLE_DEVICE && top.packet_status == `URXQ_PS_SETUP_DONE)
      |=> irq_sts[`URXQ_BIT_POPEV])
    else $error("device setup done did not raise interrupt");
  chk_size_reset: assert property (
    $rose(i_rst_b) |-> rx_fifo_size == `URXQ_SIZE_RESET)
    else $error("depth register reset value wrong");
  chk_nempty_gate: assert property (
    (!irq_mask[`URXQ_BIT_NEMPTY] && (irq_sts[1:0] & irq_mask[1:0]) == 2'b00
      && $stable(irq_mask)) |-> !o_irq)
    else $error("not-empty interrupt not gated by enable");
  chk_nempty_fires: assert property (
    (irq_mask[`URXQ_BIT_NEMPTY] && irq_sts[`URXQ_BIT_NEMPTY] && $stable(irq_mask)) |-> o_irq)
    else $error("enabled not-empty flag did not interrupt");
  chk_empty_flag: assert property (
    (count == '0 && !push) [*2] |-> !o_rx_not_empty)
    else $error("not-empty flag set while empty");
  chk_no_underflow: assert property (
    (count == '0 && !push) |=> count == '0)
    else $error("queue underflowed");
  chk_host_halt: assert property (
    (popped && i_role == urxq_pkg::ROLE_HOST && top.packet_status == `URXQ_PS_HALTED)
      |=> irq_sts[`URXQ_BIT_POPEV])
    else $error("host halted entry did not raise interrupt");
  chk_sticky_holds: assert property (
    (irq_sts[`URXQ_BIT_POPEV] && !sts_clr[`URXQ_BIT_POPEV]) |=> irq_sts[`URXQ_BIT_POPEV])
    else $error("pop event bit lost without a clear");
  chk_strb_refused: assert property (
    (do_write && !wr_full) |=> o_bvalid && o_bresp == `URXQ_RESP_SLVERR)
    else $error("partial write not refused");
  chk_size_write: assert property (
    (do_write && wr_full && wr_addr == `URXQ_OFS_SIZE)
      |=> rx_fifo_size == $past(wr_data[15:0]))
    else $error("depth register write not stored");
  chk_cap_ready: assert property (
    (count >= cap && !popped) |=> !o_rx_ready)
    else $error("ready offered beyond programmed depth");

  cov_pop_host: cover property (popped && i_role == urxq_pkg::ROLE_HOST);
  cov_pop_device: cover property (popped && i_role == urxq_pkg::ROLE_DEVICE && irq_on_pop);
  cov_full: cover property (i_rx_valid && !o_rx_ready && cap != '0);
  cov_nempty_irq: cover property (o_irq && irq_sts[`URXQ_BIT_NEMPTY]
    && irq_mask[`URXQ_BIT_NEMPTY]);
  cov_strb_refused: cover property (do_write && !wr_full);
endmodule : urxq_top

/* File: dv/urxq_link_model.sv */
// link side model that offers receive status entries
`timescale 1ns/1ps
module urxq_link_model (
  input wire logic i_sys_clk,
  input wire logic i_rx_ready,
  output logic o_rx_valid,
  output urxq_pkg::urxq_entry_s o_rx_entry
);
  initial begin
    o_rx_valid = 1'h0;
    o_rx_entry = '0;
  end
  // offer held until taken; idle lines show the inverse so no stale entry looks live
  task automatic send(input urxq_pkg::urxq_entry_s e);
    @(posedge i_sys_clk);
    o_rx_valid <= 1'h1;
    o_rx_entry <= e;
    do @(posedge i_sys_clk); while (i_rx_ready !== 1'h1);
    o_rx_valid <= 1'h0;
    o_rx_entry <= ~e;
  endtask : send
endmodule : urxq_link_model

/* File: dv/urxq_top_test.sv */
// self-checking bench for the receive status queue
`timescale 1ns/1ps
`include "urxq_defs.svh"
module urxq_top_test;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  urxq_pkg::urxq_role_e role = urxq_pkg::ROLE_HOST;
  logic rx_valid, rx_ready, irq, nempty;
  urxq_pkg::urxq_entry_s rx_entry;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  int bad_count = 0;
  int cmp_count = 0;

  always #50 clk = ~clk;

  urxq_top i_urxq_top (.i_sys_clk(clk), .i_rst_b(rst_b), .i_role(role),
    .i_rx_valid(rx_valid), .i_rx_entry(rx_entry), .o_rx_ready(rx_ready), .o_irq(irq),
    .o_rx_not_empty(nempty), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid),
    .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp));

  urxq_link_model i_urxq_link_model (.i_sys_clk(clk), .i_rx_ready(rx_ready),
    .o_rx_valid(rx_valid), .o_rx_entry(rx_entry));

  // ****************************************
  // access tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] exp);
    @(posedge clk);
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    check("write response", 32'(exp), 32'(bresp));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    @(posedge clk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    check("read data", exp, rdata);
    check("read response", 32'(rexp), 32'(rresp));
  endtask : rd

  task automatic push(input urxq_pkg::urxq_entry_s e);
    i_urxq_link_model.send(e);
    while (nempty !== 1'h1) @(posedge clk);
  endtask : push

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // tests
  // ****************************************
  initial begin
    urxq_pkg::urxq_entry_s e, f;
    logic [7:0] kn, ev;
    repeat (12) @(posedge clk);
    rst_b <= 1'h1;
    rd(`URXQ_OFS_SIZE, 32'h0000_0200, `URXQ_RESP_OKAY);
    rd(`URXQ_OFS_PEEK, 32'h0, `URXQ_RESP_OKAY);
    wr(`URXQ_OFS_SIZE, 32'h0000_0400, 4'hF, `URXQ_RESP_OKAY);
    wr(`URXQ_OFS_SIZE, 32'h0000_0001, 4'h3, `URXQ_RESP_SLVERR);
    rd(`URXQ_OFS_SIZE, 32'h0000_0400, `URXQ_RESP_OKAY);
    wr(`URXQ_OFS_POP, 32'h1, 4'hF, `URXQ_RESP_SLVERR);
    rd(8'h30, 32'h0, `URXQ_RESP_SLVERR);
    // every documented code in both roles; reserved codes have no defined meaning
    for (int h = 0; h < 2; h++) begin
      role <= h ? urxq_pkg::ROLE_HOST : urxq_pkg::ROLE_DEVICE;
      kn = h ? 8'hAC : 8'h5E;
      ev = h ? 8'hA8 : 8'h1A;
      for (int c = 1; c < 8; c++) begin
        if (kn[c]) begin
          e = '{c[3:0], c[1:0], 11'h7FF - 11'(c), 4'(15 - c)};
          push(e);
          rd(`URXQ_OFS_PEEK, {11'h0, e}, `URXQ_RESP_OKAY);
          check("irq masked", 32'h0, 32'(irq));
          rd(`URXQ_OFS_POP, {11'h0, e}, `URXQ_RESP_OKAY);
          rd(`URXQ_OFS_IRQ_STS, 32'(ev[c]), `URXQ_RESP_OKAY);
          wr(`URXQ_OFS_IRQ_STS, 32'h1, 4'hF, `URXQ_RESP_OKAY);
        end
      end
    end
    // order of two entries, an empty pop, interrupt gating
    wr(`URXQ_OFS_IRQ_MASK, 32'h11, 4'hF, `URXQ_RESP_OKAY);
    e = '{`URXQ_PS_DATA, 2'h2, 11'h040, 4'h9};
    f = '{`URXQ_PS_DONE, 2'h1, 11'h001, 4'h6};
    push(e);
    push(f);
    rd(`URXQ_OFS_IRQ_STS, 32'h10, `URXQ_RESP_OKAY);
    check("irq not empty", 32'h1, 32'(irq));
    rd(`URXQ_OFS_POP, {11'h0, e}, `URXQ_RESP_OKAY);
    rd(`URXQ_OFS_PEEK, {11'h0, f}, `URXQ_RESP_OKAY);
    rd(`URXQ_OFS_POP, {11'h0, f}, `URXQ_RESP_OKAY);
    rd(`URXQ_OFS_POP, 32'h0, `URXQ_RESP_OKAY);
    rd(`URXQ_OFS_IRQ_STS, 32'h1, `URXQ_RESP_OKAY);
    check("not empty flag", 32'h0, 32'(nempty));
    check("irq pop event", 32'h1, 32'(irq));
    wr(`URXQ_OFS_IRQ_STS, 32'h1, 4'hF, `URXQ_RESP_OKAY);
    @(posedge clk);
    check("irq cleared", 32'h0, 32'(irq));
    // depth of one: a second offer waits and marks the refusal
    wr(`URXQ_OFS_SIZE, 32'h0000_0001, 4'hF, `URXQ_RESP_OKAY);
    push(e);
    fork
      i_urxq_link_model.send(f);
    join_none
    repeat (3) @(posedge clk);
    check("rx ready at depth", 32'h0, 32'(rx_ready));
    rd(`URXQ_OFS_IRQ_STS, 32'h12, `URXQ_RESP_OKAY);
    rd(`URXQ_OFS_POP, {11'h0, e}, `URXQ_RESP_OKAY);
    while (nempty !== 1'h1) @(posedge clk);
    rd(`URXQ_OFS_POP, {11'h0, f}, `URXQ_RESP_OKAY);
    rd(`URXQ_OFS_IRQ_STS, 32'h3, `URXQ_RESP_OKAY);
    wr(`URXQ_OFS_IRQ_STS, 32'h3, 4'hF, `URXQ_RESP_OKAY);
    rd(`URXQ_OFS_IRQ_STS, 32'h0, `URXQ_RESP_OKAY);
    check("rx ready freed", 32'h1, 32'(rx_ready));
    report_and_stop();
  end

  // whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
endmodule : urxq_top_test
